// ---- rtl/tmr_pkg.sv ----
/*
 * Shared constants for the pairable 16/32-bit timer block: register map,
 * control word fields, prescaler limits and bus response codes.
 * Assumes a 32-bit AXI4-Lite slave with byte addressing.
 */
package tmr_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int TW        = 16;
  localparam int AW        = 8;
  localparam int DW        = 32;
  localparam int NPAIR     = 2;
  localparam int NTMR      = 4;
  localparam int PSC_W     = 8;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [AW-1:0] PAIR_STRIDE = 8'h20;
  localparam logic [AW-1:0] OFF_CTL_E   = 8'h00;
  localparam logic [AW-1:0] OFF_CTL_O   = 8'h04;
  localparam logic [AW-1:0] OFF_CNT_L   = 8'h08;
  localparam logic [AW-1:0] OFF_CNT_H   = 8'h0C;
  localparam logic [AW-1:0] OFF_PER_L   = 8'h10;
  localparam logic [AW-1:0] OFF_PER_H   = 8'h14;
  localparam logic [AW-1:0] OFF_STATUS  = 8'h40;
  localparam logic [AW-1:0] PAIR_MASK   = 8'h1F;

  // ************************************************************
  // Control word fields
  // ************************************************************
  localparam int CTL_ON    = 15;
  localparam int CTL_SIDL  = 13;
  localparam int CTL_GATE  = 6;
  localparam int CTL_PS_HI = 5;
  localparam int CTL_PS_LO = 4;
  localparam int CTL_JOIN  = 3;
  localparam int CTL_CS    = 1;

  localparam logic [TW-1:0] CTL_MASK_E = 16'hA07A;
  localparam logic [TW-1:0] CTL_MASK_O = 16'hA072;
  localparam logic [TW-1:0] CTL_RST    = 16'h0000;
  localparam logic [TW-1:0] PER_RST    = 16'hFFFF;
  localparam logic [TW-1:0] CNT_ALL1   = 16'hFFFF;
  localparam logic [TW-1:0] CNT_ZERO   = 16'h0000;

  // ************************************************************
  // Prescaler
  // ************************************************************
  localparam logic [1:0] PS_DIV1   = 2'h0;
  localparam logic [1:0] PS_DIV8   = 2'h1;
  localparam logic [1:0] PS_DIV64  = 2'h2;
  localparam logic [1:0] PS_DIV256 = 2'h3;
  localparam logic [PSC_W-1:0] LIM_DIV1   = 8'h00;
  localparam logic [PSC_W-1:0] LIM_DIV8   = 8'h07;
  localparam logic [PSC_W-1:0] LIM_DIV64  = 8'h3F;
  localparam logic [PSC_W-1:0] LIM_DIV256 = 8'hFF;

  function automatic logic [PSC_W-1:0] psc_limit(input logic [1:0] sel);
    logic [PSC_W-1:0] lim;
    case (sel)
      PS_DIV8:   lim = LIM_DIV8;
      PS_DIV64:  lim = LIM_DIV64;
      PS_DIV256: lim = LIM_DIV256;
      default:   lim = LIM_DIV1;
    endcase
    return lim;
  endfunction

  // ************************************************************
  // Bus
  // ************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [DW-1:0] RD_ZERO  = 32'h0000_0000;

endpackage

// ---- rtl/tmr_pair.sv ----
/*
 * One timer pair: even and odd 16-bit timers with prescalers, joinable
 * into one 32-bit timer. Control and period words come from the top.
 * Assumes ext_rise and gate are already synchronised to aclk.
 */
`timescale 1ns/1ps
module tmr_pair
  import tmr_pkg::*;
#(
  parameter bit HAS_TRIG = 1'b1
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          idle,
  input  wire logic [TW-1:0] ctrl_even,
  input  wire logic [TW-1:0] ctrl_odd,
  input  wire logic [TW-1:0] per_lo,
  input  wire logic [TW-1:0] per_hi,
  input  wire logic [1:0]    ext_rise,
  input  wire logic [1:0]    gate,
  input  wire logic [1:0]    ctrl_wr,
  input  wire logic [1:0]    cnt_wr,
  input  wire logic [TW-1:0] cnt_wdata,
  output logic      [TW-1:0] cnt_lo,
  output logic      [TW-1:0] cnt_hi,
  output logic      [1:0]    match,
  output logic               adc_trig
);

  // ************************************************************
  // Per-timer clock path
  // ************************************************************
  logic             join_on;
  logic [TW-1:0]    cfg    [2];
  logic [PSC_W-1:0] pres_r [2];
  logic [1:0]       inc;
  logic [1:0]       tick;
  logic [1:0]       pclr;

  assign join_on = ctrl_even[CTL_JOIN];
  assign cfg[0]  = ctrl_even;
  assign cfg[1]  = join_on ? ctrl_even : ctrl_odd;

  for (genvar i = 0; i < 2; i++) begin : g_tmr
    logic sel;
    logic run;
    logic src;
    logic gok;
    logic [PSC_W-1:0] lim;
    assign sel = join_on ? 1'b0 : i[0];
    assign run = cfg[i][CTL_ON]
               & ~(cfg[i][CTL_SIDL] & idle);
    assign src = cfg[i][CTL_CS] ? ext_rise[sel] : 1'b1;
    assign gok = cfg[i][CTL_CS] | ~cfg[i][CTL_GATE]
               | gate[sel];
    assign lim = psc_limit(cfg[i][CTL_PS_HI:CTL_PS_LO]);
    assign inc[i]  = run & src & gok;
    assign tick[i] = inc[i] & (pres_r[i] == lim);
    // Joined mode: only the even word's write touches the shared path
    assign pclr[i] = (join_on ? ctrl_wr[0] : ctrl_wr[i])
                   & cfg[i][CTL_ON];

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pres_r[i] <= '0;
      end else if (pclr[i]) begin
        pres_r[i] <= '0;
      end else if (inc[i]) begin
        pres_r[i] <= tick[i] ? '0 : pres_r[i] + 1'b1;
      end
    end
  end

  // ************************************************************
  // Counters
  // ************************************************************
  logic lo_eq;
  logic hi_eq;
  logic full_eq;
  logic m_even;
  logic m_odd;

  assign lo_eq   = (cnt_lo == per_lo);
  assign hi_eq   = (cnt_hi == per_hi);
  assign full_eq = lo_eq & hi_eq;
  assign m_even  = ~join_on & tick[0] & lo_eq;
  assign m_odd   = join_on ? (tick[0] & full_eq)
                           : (tick[1] & hi_eq);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_lo <= CNT_ZERO;
    end else if (cnt_wr[0]) begin
      cnt_lo <= cnt_wdata;
    end else if (tick[0]) begin
      if (join_on ? full_eq : lo_eq) begin
        cnt_lo <= CNT_ZERO;
      end else begin
        cnt_lo <= cnt_lo + 1'b1;
      end
    end
  end

  // Upper word follows the even clock path while joined
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_hi <= CNT_ZERO;
    end else if (cnt_wr[1]) begin
      cnt_hi <= cnt_wdata;
    end else if (join_on) begin
      if (tick[0] & full_eq) begin
        cnt_hi <= CNT_ZERO;
      end else if (tick[0] & (cnt_lo == CNT_ALL1)) begin
        cnt_hi <= cnt_hi + 1'b1;
      end
    end else if (tick[1]) begin
      cnt_hi <= hi_eq ? CNT_ZERO : cnt_hi + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match    <= 2'b00;
      adc_trig <= 1'b0;
    end else begin
      match    <= {m_odd, m_even};
      adc_trig <= HAS_TRIG & m_odd;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  run_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg[0][CTL_ON] && !cnt_wr[0] |=> $stable(cnt_lo))
    else $error("even count moved while stopped");
  idle_halt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    idle && cfg[0][CTL_SIDL] && !cnt_wr[0] |=> $stable(cnt_lo))
    else $error("even count moved in idle");
  gate_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg[0][CTL_CS] && cfg[0][CTL_GATE] && !gate[0] && !cnt_wr[0]
    |=> $stable(cnt_lo))
    else $error("even count moved with gate low");
  psc_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_wr[0] && ctrl_even[CTL_ON] |=> pres_r[0] == '0)
    else $error("prescaler not cleared on control write");
  carry_up_a: assert property (@(posedge aclk) disable iff (!aresetn)
    join_on && tick[0] && cnt_lo == CNT_ALL1 && !full_eq && !cnt_wr[1]
    |=> cnt_hi == $past(cnt_hi) + 1'b1)
    else $error("carry into upper word lost");
  odd_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
    join_on && !tick[0] && !cnt_wr[1] |=> $stable(cnt_hi))
    else $error("upper word moved without even tick");
  wrap_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    m_odd && !cnt_wr[1] |=> cnt_hi == CNT_ZERO && match[1])
    else $error("no wrap to zero after match");
  join_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(join_on) |-> !match[0])
    else $error("even flag raised in joined mode");

endmodule

// ---- rtl/tmr_top.sv ----
/*
 * Top of the pairable timer block: AXI4-Lite register slave, pin
 * synchronisers, sticky event flags and two timer pairs.
 * Assumes a single clock aclk; timer pins are asynchronous to it and
 * idle comes from logic on aclk.
 */
// Local design decisions: the AXI4-Lite register port and the address map.
// Function
// - Run bit starts or stops the timer
// - Idle-stop bit halts counting in idle
// - Gate bit counts only with gate high, internal clock only
// - Prescale codes divide by 1, 8, 64, 256
// - Join bit bit 3 forms 32-bit timer
// - Clock-source bit selects pin rising edges
// - Odd control ignored while joined
// - Joined uses even clock, odd flag
// - Joined period: odd high, even low
// - Odd count holds upper joined word
// - Control write while running clears prescaler
// - ADC trigger only from first pair odd
// - Joined match on full 32-bit period
// - Each timer runs as timer or counter
// - Unimplemented control bits read zero
// - Second pair join bit behaves alike
`timescale 1ns/1ps
module tmr_top
  import tmr_pkg::*;
(
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic [AW-1:0]   s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [DW-1:0]   s_axi_wdata,
  input  wire logic [DW/8-1:0] s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic      [1:0]      s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [AW-1:0]   s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic      [DW-1:0]   s_axi_rdata,
  output logic      [1:0]      s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic            idle,
  input  wire logic [NTMR-1:0] external_timer_clock_pin,
  input  wire logic [NTMR-1:0] gate_pin,
  output logic      [NTMR-1:0] match_flag,
  output logic                 adc_trig
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [NTMR-1:0] ck_s1_r;
  logic [NTMR-1:0] ck_s2_r;
  logic [NTMR-1:0] ck_s3_r;
  logic [NTMR-1:0] gt_s1_r;
  logic [NTMR-1:0] gt_s2_r;
  logic [NTMR-1:0] ext_rise;

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ck_s1_r <= '0;
      ck_s2_r <= '0;
      ck_s3_r <= '0;
      gt_s1_r <= '0;
      gt_s2_r <= '0;
    end else begin
      ck_s1_r <= external_timer_clock_pin;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
      gt_s1_r <= gate_pin;
      gt_s2_r <= gt_s1_r;
    end
  end

  // Pin edges narrower than one aclk period may be missed
  assign ext_rise = ck_s2_r & ~ck_s3_r;

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  logic            aw_hold_r;
  logic            w_hold_r;
  logic [AW-1:0]   awaddr_r;
  logic [DW-1:0]   wdata_r;
  logic [1:0]      wstrb_r;
  logic            do_wr;
  logic            wr_hit;

  assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;
  assign do_wr         = aw_hold_r & w_hold_r & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      awaddr_r  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_r <= 1'b0;
      wdata_r  <= RD_ZERO;
      wstrb_r  <= 2'b00;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb[1:0];
    end else if (do_wr) begin
      w_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Address decode
  // ************************************************************
  logic [AW-1:0] wr_off;
  logic          wr_pair;
  logic          wr_inp;
  logic          wr_stat;

  assign wr_off  = awaddr_r & PAIR_MASK;
  assign wr_pair = awaddr_r[AW-3];
  assign wr_inp  = (awaddr_r < OFF_STATUS) && (wr_off <= OFF_PER_H)
                 && (awaddr_r[1:0] == 2'b00);
  assign wr_stat = (awaddr_r == OFF_STATUS);
  assign wr_hit  = wr_inp | wr_stat;

  function automatic logic [TW-1:0] merge(input logic [TW-1:0] old,
                                          input logic [TW-1:0] nw,
                                          input logic [1:0]    strb);
    logic [TW-1:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = nw[7:0];
    end
    if (strb[1]) begin
      res[15:8] = nw[15:8];
    end
    return res;
  endfunction

  // ************************************************************
  // Control and period registers
  // ************************************************************
  logic [TW-1:0]   ctl_r [NTMR];
  logic [TW-1:0]   per_r [NTMR];
  logic [TW-1:0]   cnt   [NTMR];
  logic [NTMR-1:0] ctl_wr;
  logic [NTMR-1:0] cnt_wr;

  for (genvar t = 0; t < NTMR; t++) begin : g_reg
    localparam logic [AW-1:0] CTL_OFF = t[0] ? OFF_CTL_O : OFF_CTL_E;
    localparam logic [AW-1:0] CNT_OFF = t[0] ? OFF_CNT_H : OFF_CNT_L;
    localparam logic [AW-1:0] PER_OFF = t[0] ? OFF_PER_H : OFF_PER_L;
    localparam logic [TW-1:0] MASK    = t[0] ? CTL_MASK_O : CTL_MASK_E;
    logic in_pair;
    assign in_pair   = do_wr & wr_inp & (wr_pair == t[1]);
    assign ctl_wr[t] = in_pair & (wr_off == CTL_OFF);
    assign cnt_wr[t] = in_pair & (wr_off == CNT_OFF);

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ctl_r[t] <= CTL_RST;
      end else if (ctl_wr[t]) begin
        ctl_r[t] <= merge(ctl_r[t], wdata_r[TW-1:0], wstrb_r)
                  & MASK;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        per_r[t] <= PER_RST;
      end else if (in_pair && wr_off == PER_OFF) begin
        per_r[t] <= merge(per_r[t], wdata_r[TW-1:0], wstrb_r);
      end
    end
  end

  // ************************************************************
  // Timer pairs
  // ************************************************************
  logic [NTMR-1:0] match;
  logic [NPAIR-1:0] trig;

  for (genvar p = 0; p < NPAIR; p++) begin : g_pair
    logic [TW-1:0] cnt_wdata;
    assign cnt_wdata = merge(cnt[2*p + (cnt_wr[2*p+1] ? 1 : 0)],
                             wdata_r[TW-1:0], wstrb_r);
    tmr_pair #(
      .HAS_TRIG  (p == 0)
    ) u_pair (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .idle      (idle),
      .ctrl_even (ctl_r[2*p]),
      .ctrl_odd  (ctl_r[2*p+1]),
      .per_lo    (per_r[2*p]),
      .per_hi    (per_r[2*p+1]),
      .ext_rise  (ext_rise[2*p+1:2*p]),
      .gate      (gt_s2_r[2*p+1:2*p]),
      .ctrl_wr   (ctl_wr[2*p+1:2*p]),
      .cnt_wr    (cnt_wr[2*p+1:2*p]),
      .cnt_wdata (cnt_wdata),
      .cnt_lo    (cnt[2*p]),
      .cnt_hi    (cnt[2*p+1]),
      .match     (match[2*p+1:2*p]),
      .adc_trig  (trig[p])
    );
  end

  assign adc_trig = trig[0];

  // ************************************************************
  // Sticky flags, write one to clear
  // ************************************************************
  logic [NTMR-1:0] clr;

  assign clr = (do_wr && wr_stat) ?
               (wdata_r[NTMR-1:0] & {NTMR{wstrb_r[0]}}) : '0;

  // A match in the clearing cycle is kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_flag <= '0;
    end else begin
      match_flag <= (match_flag & ~clr) | match;
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  logic [AW-1:0] rd_off;
  logic          rd_pair;
  logic          rd_inp;
  logic [DW-1:0] rd_val;
  logic          rd_ok;

  assign rd_off  = s_axi_araddr & PAIR_MASK;
  assign rd_pair = s_axi_araddr[AW-3];
  assign rd_inp  = (s_axi_araddr < OFF_STATUS)
                 && (s_axi_araddr[1:0] == 2'b00);

  always_comb begin
    rd_val = RD_ZERO;
    rd_ok  = 1'b1;
    if (s_axi_araddr == OFF_STATUS) begin
      rd_val[NTMR-1:0] = match_flag;
    end else if (!rd_inp) begin
      rd_ok = 1'b0;
    end else begin
      case (rd_off)
        OFF_CTL_E: rd_val[TW-1:0] = ctl_r[2*rd_pair];
        OFF_CTL_O: rd_val[TW-1:0] = ctl_r[2*rd_pair+1];
        OFF_CNT_L: rd_val[TW-1:0] = cnt[2*rd_pair];
        OFF_CNT_H: rd_val[TW-1:0] = cnt[2*rd_pair+1];
        OFF_PER_L: rd_val[TW-1:0] = per_r[2*rd_pair];
        OFF_PER_H: rd_val[TW-1:0] = per_r[2*rd_pair+1];
        default:   rd_ok = 1'b0;
      endcase
    end
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= RD_ZERO;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  ctl_rsvd_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctl_r[0] & ~CTL_MASK_E) == '0
    && (ctl_r[1] & ~CTL_MASK_O) == '0)
    else $error("unimplemented control bit set");
  trig_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    adc_trig |-> match[1] ##1 match_flag[1])
    else $error("trigger without odd flag");
  pair2_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl_r[2][CTL_JOIN] && $past(ctl_r[2][CTL_JOIN])
    |-> !match[2])
    else $error("second pair even flag in joined mode");
  flag_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    match[1] |=> match_flag[1])
    else $error("match event lost");
  ctl_rsvd2_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (ctl_r[2] & ~CTL_MASK_E) == '0 && (ctl_r[3] & ~CTL_MASK_O) == '0)
    else $error("unimplemented control bit set in pair one");
  trig_only_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    match[3] && !match[1] |-> !adc_trig)
    else $error("trigger from second pair");
  // Joined wrap must clear both halves on one tick
  join_wrap_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    $past(ctl_r[0][CTL_JOIN]) && match[1] && $past(cnt_wr[1:0]) == 2'b00
    |-> cnt[0] == CNT_ZERO && cnt[1] == CNT_ZERO)
    else $error("joined count not zero after match");
  join2_wrap_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    $past(ctl_r[2][CTL_JOIN]) && match[3] && $past(cnt_wr[3:2]) == 2'b00
    |-> cnt[2] == CNT_ZERO && cnt[3] == CNT_ZERO)
    else $error("second pair joined count not zero after match");
  flag_clear_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    clr[0] && !match[0] |=> !match_flag[0])
    else $error("flag not cleared by write");

endmodule

// ---- testbench/test_tmr_top.sv ----
/*
 * Self-checking bench for the pairable timer: AXI4-Lite register tasks
 * and timer scenarios. Assumes tmr_top with a 40 MHz aclk.
 */
`timescale 1ns/1ps
module test_tmr_top;
  import tmr_pkg::*;
  // ************************************************************
  // Signals
  // ************************************************************
  logic aclk = 0, aresetn = 0, idle = 0;
  logic [AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DW-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h3, ext_pin = '0, gate_pin = '0, match_flag;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, adc_trig;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int fails = 0, comparisons = 0, adc_n = 0, lim[4] = '{1, 8, 64, 256};
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) if (adc_trig === 1'b1) adc_n <= adc_n + 1;
  tmr_top DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .idle(idle),
    .external_timer_clock_pin(ext_pin), .gate_pin(gate_pin),
    .match_flag(match_flag), .adc_trig(adc_trig));
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  // Handshakes judged at negedge; ready is stable until the next edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic da, dw, b;
    da = 0;
    dw = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(negedge aclk);
      b = s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) da = 1;
      if (s_axi_wvalid && s_axi_wready) dw = 1;
      if (b) chk("bresp", RESP_OKAY, s_axi_bresp);
      @(posedge aclk);
      if (da) s_axi_awvalid <= 0;
      if (dw) s_axi_wvalid <= 0;
    end while (!b);
    s_axi_bready <= 0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    logic v;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(negedge aclk);
      v = s_axi_rvalid;
      if (v) chk("rdata", e, s_axi_rdata);
      if (v) chk("rresp", r, s_axi_rresp);
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!v);
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic clr;
    wr(OFF_CTL_E, 16'h0000);
    wr(OFF_CNT_L, 16'h0000);
    wr(OFF_STATUS, 16'h000F);
  endtask
  task automatic end_sim;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Whole run is near 1100 cycles
  initial begin
    #150000;
    fails++;
    end_sim;
  end
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    cyc(2);
    aresetn <= 1;
    @(posedge aclk);
    rd(OFF_CTL_E, 32'h0000_0000, RESP_OKAY);
    rd(OFF_PER_L, 32'h0000_FFFF, RESP_OKAY);
    wr(OFF_CTL_O, 16'hFFFF);
    rd(OFF_CTL_O, 32'h0000_A072, RESP_OKAY);
    wr(OFF_CTL_O, 16'h0000);
    rd(8'h18, RD_ZERO, RESP_SLVERR);
    $display("registers done");
    wr(OFF_PER_L, 16'h0001);
    clr;
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CTL_E, 16'h8000 | 16'(i << 4));
      cyc(lim[i]);
      if (lim[i] > 1) chk("flag early", 0, match_flag);
      cyc(lim[i] + 8);
      chk("flag", 1, match_flag);
      clr;
    end
    $display("prescale done");
    idle <= 1;
    wr(OFF_CTL_E, 16'hA000);
    cyc(20);
    chk("idle flag", 0, match_flag);
    idle <= 0;
    cyc(10);
    chk("wake flag", 1, match_flag);
    clr;
    wr(OFF_CTL_E, 16'h8040);
    cyc(20);
    chk("gated flag", 0, match_flag);
    gate_pin[0] <= 1;
    cyc(10);
    chk("gate flag", 1, match_flag);
    gate_pin[0] <= 0;
    clr;
    // Gate bit set but gate low: external clock must still count
    wr(OFF_CTL_E, 16'h8042);
    cyc(20);
    chk("no edge flag", 0, match_flag);
    repeat (2) begin
      ext_pin[0] <= 1;
      cyc(3);
      ext_pin[0] <= 0;
      cyc(3);
    end
    cyc(8);
    chk("edge flag", 1, match_flag);
    clr;
    $display("modes done");
    wr(OFF_PER_L, 16'h0000);
    wr(OFF_PER_H, 16'h0002);
    wr(OFF_CNT_L, 16'hFFFE);
    wr(OFF_CNT_H, 16'h0000);
    wr(OFF_CTL_O, 16'h0030);
    wr(OFF_CTL_E, 16'h8008);
    cyc(6);
    wr(OFF_CTL_E, 16'h0008);
    rd(OFF_CNT_H, 32'h0000_0001, RESP_OKAY);
    wr(OFF_PER_L, 16'h0003);
    wr(OFF_PER_H, 16'h0001);
    wr(OFF_CNT_L, 16'h0000);
    wr(OFF_CTL_E, 16'h8008);
    cyc(12);
    chk("joined flag", 4'h2, match_flag);
    chk("adc joined", 1, adc_n);
    clr;
    $display("joined done");
    wr(PAIR_STRIDE + OFF_PER_H, 16'h0001);
    wr(PAIR_STRIDE + OFF_CTL_O, 16'h8000);
    cyc(10);
    chk("pair1 flag", 4'h8, match_flag);
    chk("adc pair1", 1, adc_n);
    // Second pair joined: period 0x0001_0002 from count 0x0001_0000
    wr(PAIR_STRIDE + OFF_CTL_O, 16'h0000);
    wr(OFF_STATUS, 16'h000F);
    wr(PAIR_STRIDE + OFF_PER_L, 16'h0002);
    wr(PAIR_STRIDE + OFF_CNT_H, 16'h0001);
    wr(PAIR_STRIDE + OFF_CNT_L, 16'h0000);
    wr(PAIR_STRIDE + OFF_CTL_E, 16'h8008);
    cyc(10);
    chk("pair1 joined flag", 4'h8, match_flag);
    rd(PAIR_STRIDE + OFF_CNT_H, 32'h0000_0000, RESP_OKAY);
    chk("adc pair1 joined", 1, adc_n);
    $display("second pair done");
    end_sim;
  end
endmodule
